/* design/tad_pkg.sv */
// Purpose: Shared constants and carrier types for the text attribute decoder.
// Assumes: One 40 MHz clock; all control bits arrive as plain ports.
// Notes: Field positions and counts are named once here; some decode still uses literal bit ranges.
package tad_pkg;

  // ---------------------------------------------------------------------------
  // Attribute byte field positions (alternate terminal format)
  // ---------------------------------------------------------------------------
  localparam int unsigned ATTR_BLINK_BIT = 7;  // Blink or bright background.
  localparam int unsigned ATTR_REV_BIT = 6;    // Reverse video.
  localparam int unsigned ATTR_UL_BIT = 5;     // Underline.
  localparam int unsigned ATTR_SEP_BIT = 4;    // Column separator.
  localparam int unsigned ATTR_INT_BIT = 3;    // Intensity and font set select.

  // ---------------------------------------------------------------------------
  // Colour indices and cell geometry
  // ---------------------------------------------------------------------------
  localparam logic [3:0] COLOR_DARK = 4'h0;    // Normal background index.
  localparam logic [3:0] COLOR_BRIGHT = 4'h8;  // Bright background index.
  localparam logic [3:0] CELL_LAST_NARROW = 4'h7;  // Last pixel of an 8-wide cell.
  localparam logic [3:0] CELL_LAST_WIDE = 4'h8;    // Last pixel of a 9-wide cell.
  localparam logic [7:0] WIDE_HTOTAL_ADJ = 8'h01;    // Wide text: total is count - 1.
  localparam logic [7:0] LEGACY_HTOTAL_ADJ = 8'h05;  // Legacy text: total is count - 5.

  // ---------------------------------------------------------------------------
  // Blink divider bit positions on the vertical sync counter
  // ---------------------------------------------------------------------------
  localparam int unsigned BLINK_CNT_W = 6;     // Counts up to sync / 64.
  localparam int unsigned DIV16_BIT = 3;       // Toggles every 8 syncs.
  localparam int unsigned DIV32_BIT = 4;       // Toggles every 16 syncs.
  localparam int unsigned DIV64_BIT = 5;       // Toggles every 32 syncs.

  // ---------------------------------------------------------------------------
  // Register banks and the memory-mapped window
  // ---------------------------------------------------------------------------
  localparam int unsigned IO_BANK_REGS = 16;       // Extended mode I/O registers.
  localparam int unsigned MMIO_BANK_REGS = 128;    // Coprocessor registers.
  localparam int unsigned BLOCK_ADDR_W = 13;       // 8 KB assigned block.
  localparam logic [2:0] MMIO_TOP_KB = 3'h7;       // Top 1 KB of the 8 KB block.
  localparam logic [7:0] IDX_HSYNC_END = 8'h1A;    // Extended sync end index.
  localparam logic [7:0] IDX_HSYNC_POS_LO = 8'h1C; // Extended sync position indices.
  localparam logic [7:0] IDX_HSYNC_POS_HI = 8'h1E;
  localparam logic [7:0] IDX_ALT_ATTR_CTRL = 8'h6D; // Alternate attribute control.
  localparam logic [15:0] ATTR_MODE_PORT = 16'h03C0; // Legacy attribute port.
  localparam logic [7:0] ATTR_MODE_INDEX = 8'h10;    // Legacy mode control index.

  // ---------------------------------------------------------------------------
  // Packed pixel sizes
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    TAD_BPP1 = 3'h0,
    TAD_BPP2 = 3'h1,
    TAD_BPP4 = 3'h3,
    TAD_BPP8 = 3'h2,
    TAD_BPP16 = 3'h6
  } tad_bpp_t;

  // Alternate attribute control contents (index 6D).
  typedef struct packed {
    logic enable;          // Alternate attribute decoding on.
    logic cursor_blink;    // Cursor blinks at the alternate rate.
    logic cursor_block;    // 1: full cell cursor, 0: underline-row cursor.
    logic [3:0] cursor_color;  // Cursor colour index.
  } tad_alt_ctrl_t;

  // Legacy and extended horizontal timing fields.
  typedef struct packed {
    logic [7:0] htotal;        // Horizontal total as loaded by software.
    logic [4:0] legacy_hsync_end;   // Legacy retrace end field.
    logic [1:0] legacy_hsync_delay; // Legacy retrace delay field.
    logic legacy_hblank_end_b5;     // Legacy blanking end, bit 5.
    logic [7:0] ext_hsync_end;      // Extended sync end (index 1A).
    logic [7:0] ext_hsync_pos_lo;   // Extended sync position (index 1C).
    logic [7:0] ext_hsync_pos_hi;   // Extended sync position (index 1E).
  } tad_htiming_t;

  // Decoded attribute fields.
  typedef struct packed {
    logic blink;
    logic reverse;
    logic underline;
    logic separator;
    logic intensity;
    logic [2:0] rgb;
  } tad_attr_t;

endpackage : tad_pkg

/* design/tad_text_attribute_decoder.sv */
// Purpose: Text cell colour decode, blink timing, wide text timing selection,
//          packed pixel extraction and register window decode.
// Assumes: All inputs synchronous to clk_in; vsync_pulse_in is one cycle wide.
// Notes: Colour and pixel outputs are registered, one cycle after their inputs.
`timescale 1ns/1ps

module tad_text_attribute_decoder (
  input wire logic clk_in,
  input wire logic rst_in,
  // Mode and configuration.
  input wire logic enhanced_variant_in,
  input wire logic legacy_text_mode_in,
  input wire logic wide_text_mode_in,
  input wire logic opmode_alt_attr_in,
  input wire tad_pkg::tad_alt_ctrl_t alt_ctrl_in,
  input wire logic attr_blink_enable_in,
  input wire logic cell_nine_wide_in,
  input wire tad_pkg::tad_htiming_t htiming_in,
  // Text pixel stream.
  input wire logic vsync_pulse_in,
  input wire logic text_pixel_valid_in,
  input wire logic [7:0] attr_byte_in,
  input wire logic font_bit_in,
  input wire logic [3:0] cell_col_in,
  input wire logic underline_row_in,
  input wire logic cursor_cell_in,
  input wire logic legacy_cursor_row_in,
  // Packed pixel stream.
  input wire logic gfx_pixel_valid_in,
  input wire logic [15:0] gfx_bytes_in,
  input wire logic [2:0] gfx_bpp_in,
  input wire logic [2:0] gfx_pixel_num_in,
  input wire logic gfx_big_endian_in,
  // Register window addresses.
  input wire logic [12:0] mem_offset_in,
  input wire logic [3:0] io_offset_in,
  // Outputs.
  output logic text_color_valid_out,
  output logic [3:0] text_color_out,
  output logic font_set_sel_out,
  output logic [3:0] cell_last_col_out,
  output logic alt_attr_active_out,
  output logic legacy_cursor_on_out,
  output logic legacy_char_on_out,
  output logic alt_cursor_on_out,
  output logic alt_char_on_out,
  output logic [8:0] htotal_chars_out,
  output logic [7:0] hsync_end_out,
  output logic hsync_end_extended_out,
  output logic [15:0] hsync_pos_out,
  output logic hsync_pos_extended_out,
  output logic hblank_end_b5_out,
  output logic gfx_valid_out,
  output logic [7:0] palette_addr_out,
  output logic [15:0] direct_color_out,
  output logic gfx_direct_out,
  output logic mmio_hit_out,
  output logic [6:0] mmio_index_out,
  output logic [3:0] io_index_out
);

  // ---------------------------------------------------------------------------
  // Mode qualification
  // ---------------------------------------------------------------------------

  // Alternate decoding needs the enhanced part, a text mode and both enables.
  wire logic any_text_mode;
  wire logic alt_active;
  assign any_text_mode = legacy_text_mode_in | wide_text_mode_in;
  assign alt_active = enhanced_variant_in & any_text_mode & opmode_alt_attr_in &
                      alt_ctrl_in.enable;
  assign alt_attr_active_out = alt_active;

  // The basic variant is fixed at 8-pixel cells; only the enhanced one may use 9.
  wire logic nine_wide;
  assign nine_wide = enhanced_variant_in & cell_nine_wide_in;
  assign cell_last_col_out = nine_wide ? tad_pkg::CELL_LAST_WIDE :
                             tad_pkg::CELL_LAST_NARROW;

  // ---------------------------------------------------------------------------
  // Horizontal timing selection for wide text
  // ---------------------------------------------------------------------------

  // The character count follows the adjust that software used when loading it.
  wire logic [7:0] htotal_adj;
  assign htotal_adj = wide_text_mode_in ? tad_pkg::WIDE_HTOTAL_ADJ :
                      tad_pkg::LEGACY_HTOTAL_ADJ;
  assign htotal_chars_out = {1'b0, htiming_in.htotal} + {1'b0, htotal_adj};

  // Wide text ignores the legacy end and delay fields and takes the extended ones.
  assign hsync_end_extended_out = wide_text_mode_in;
  assign hsync_end_out = wide_text_mode_in ? htiming_in.ext_hsync_end :
                         {3'h0, htiming_in.legacy_hsync_end};
  assign hsync_pos_extended_out = wide_text_mode_in;
  assign hsync_pos_out = wide_text_mode_in ?
                         {htiming_in.ext_hsync_pos_hi, htiming_in.ext_hsync_pos_lo} :
                         {14'h0000, htiming_in.legacy_hsync_delay};

  // Blanking end bit 5 passes through in every text mode.
  assign hblank_end_b5_out = htiming_in.legacy_hblank_end_b5;

  // ---------------------------------------------------------------------------
  // Blink timing
  // ---------------------------------------------------------------------------

  // Free-running count of vertical syncs; every blink phase is decoded from its bits.
  logic [tad_pkg::BLINK_CNT_W-1:0] sync_count;
  wire logic [tad_pkg::BLINK_CNT_W-1:0] next_sync_count;
  assign next_sync_count = sync_count + 6'h01;

  // Count only on the sync pulse so the rates scale with the refresh rate.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sync_count <= 6'h00;
    end else if (vsync_pulse_in) begin
      sync_count <= next_sync_count;
    end
  end

  // Legacy: cursor /16 and characters /32, both half on.  Alternate: cursor /32
  // half on, characters /64 on for three quarters (off only when both top bits set).
  assign legacy_cursor_on_out = ~sync_count[tad_pkg::DIV16_BIT];
  assign legacy_char_on_out = ~sync_count[tad_pkg::DIV32_BIT];
  assign alt_cursor_on_out = ~sync_count[tad_pkg::DIV32_BIT];
  assign alt_char_on_out = ~(sync_count[tad_pkg::DIV64_BIT] &
                             sync_count[tad_pkg::DIV32_BIT]);

  // ---------------------------------------------------------------------------
  // Attribute field decode
  // ---------------------------------------------------------------------------

  // Overlay the byte on the field layout.
  wire tad_pkg::tad_attr_t attr;
  assign attr = tad_pkg::tad_attr_t'(attr_byte_in);

  // Foreground is intensity over the three colour bits, as in legacy text.
  wire logic [3:0] fg_normal;
  assign fg_normal = {attr.intensity, attr.rgb};

  // The intensity bit also picks the font set in both attribute formats.
  wire logic font_set_sel;
  assign font_set_sel = attr_byte_in[tad_pkg::ATTR_INT_BIT];

  // With blinking off the top bit means a bright background instead.
  wire logic bg_bright;
  wire logic blink_request;
  assign bg_bright = ~attr_blink_enable_in & attr.blink;
  assign blink_request = attr_blink_enable_in & attr.blink;

  // ---------------------------------------------------------------------------
  // Alternate attribute colour path
  // ---------------------------------------------------------------------------

  // Base background index is 0, or 8 with the bright background.
  wire logic [3:0] alt_base_bg;
  assign alt_base_bg = bg_bright ? tad_pkg::COLOR_BRIGHT : tad_pkg::COLOR_DARK;

  // Reverse swaps roles; the foreground then becomes the base background index.
  wire logic [3:0] alt_fg;
  wire logic [3:0] alt_bg;
  assign alt_fg = attr.reverse ? alt_base_bg : fg_normal;
  assign alt_bg = attr.reverse ? fg_normal : alt_base_bg;

  // Edge pixels of the cell on the underline row carry the separator.
  wire logic edge_col;
  wire logic sep_pixel;
  wire logic ul_pixel;
  assign edge_col = (cell_col_in == 4'h0) | (cell_col_in == cell_last_col_out);
  assign sep_pixel = attr.separator & underline_row_in & edge_col;
  assign ul_pixel = attr.underline & underline_row_in;

  // A blinking character's glyph shows only its background in the off phase.
  wire logic alt_glyph_on;
  assign alt_glyph_on = font_bit_in & ~(blink_request & ~alt_char_on_out);

  // The cursor follows the alternate control register: shape, blink and colour.
  wire logic alt_cursor_shape;
  wire logic alt_cursor_lit;
  assign alt_cursor_shape = alt_ctrl_in.cursor_block | underline_row_in;
  assign alt_cursor_lit = cursor_cell_in & alt_cursor_shape &
                          (~alt_ctrl_in.cursor_blink | alt_cursor_on_out);

  // Priority: cursor, then separator (stays visible over underline), then
  // underline, then glyph.  Separator uses background when underline is set so
  // the two never merge into one solid bar.
  logic [3:0] alt_color;
  always_comb begin
    if (alt_cursor_lit) begin
      alt_color = alt_ctrl_in.cursor_color;
    end else if (sep_pixel) begin
      alt_color = attr.underline ? alt_bg : alt_fg;
    end else if (ul_pixel) begin
      alt_color = alt_fg;
    end else if (alt_glyph_on) begin
      alt_color = alt_fg;
    end else begin
      alt_color = alt_bg;
    end
  end

  // ---------------------------------------------------------------------------
  // Legacy attribute colour path
  // ---------------------------------------------------------------------------

  // Background is three bits, or four when the top bit is used for brightness.
  wire logic [3:0] legacy_bg;
  assign legacy_bg = attr_blink_enable_in ? {1'b0, attr_byte_in[6:4]} :
                     attr_byte_in[7:4];

  // Legacy underline is a colour decode: blue-only foreground on black.
  wire logic legacy_ul;
  assign legacy_ul = underline_row_in & (attr_byte_in[6:4] == 3'h0) &
                     (attr_byte_in[2:0] == 3'h1);

  // Legacy blinking uses the legacy character rate.
  wire logic legacy_glyph_on;
  assign legacy_glyph_on = (font_bit_in | legacy_ul) &
                           ~(blink_request & ~legacy_char_on_out);

  // Legacy cursor takes its shape from the row hit and the foreground colour.
  wire logic legacy_cursor_lit;
  assign legacy_cursor_lit = cursor_cell_in & legacy_cursor_row_in & legacy_cursor_on_out;

  wire logic [3:0] legacy_color;
  assign legacy_color = (legacy_cursor_lit | legacy_glyph_on) ? fg_normal : legacy_bg;

  // ---------------------------------------------------------------------------
  // Text output register
  // ---------------------------------------------------------------------------

  // Colour leaves a register so the palette sees a clean index each cycle.
  wire logic [3:0] next_text_color;
  assign next_text_color = alt_active ? alt_color : legacy_color;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      text_color_valid_out <= 1'b0;
      text_color_out <= 4'h0;
      font_set_sel_out <= 1'b0;
    end else begin
      text_color_valid_out <= text_pixel_valid_in & any_text_mode;
      if (text_pixel_valid_in) begin
        text_color_out <= next_text_color;
        font_set_sel_out <= font_set_sel;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Packed pixel extraction
  // ---------------------------------------------------------------------------

  // Bits per pixel as a shift exponent (1, 2, 4, 8 -> 0..3).
  logic [1:0] bpp_log;
  logic [7:0] bpp_mask;
  always_comb begin
    case (gfx_bpp_in)
      tad_pkg::TAD_BPP1: begin
        bpp_log = 2'h0;
        bpp_mask = 8'h01;
      end
      tad_pkg::TAD_BPP2: begin
        bpp_log = 2'h1;
        bpp_mask = 8'h03;
      end
      tad_pkg::TAD_BPP4: begin
        bpp_log = 2'h2;
        bpp_mask = 8'h0F;
      end
      default: begin
        bpp_log = 2'h3;
        bpp_mask = 8'hFF;
      end
    endcase
  end

  // Little-endian puts pixel n at bit n*bpp; big-endian counts from the top.
  wire logic [2:0] pix_shift_le;
  wire logic [2:0] pix_shift_be;
  wire logic [2:0] pix_shift;
  wire logic [7:0] pix_byte;
  assign pix_shift_le = 3'(gfx_pixel_num_in << bpp_log);
  assign pix_shift_be = 3'(~pix_shift_le - 3'((8'h01 << bpp_log) - 8'h01));
  assign pix_shift = gfx_big_endian_in ? pix_shift_be : pix_shift_le;
  assign pix_byte = gfx_bytes_in[7:0];

  // Direct colour spans two bytes; big-endian stores the high byte first.
  wire logic is_direct;
  wire logic [15:0] direct_word;
  assign is_direct = (gfx_bpp_in == tad_pkg::TAD_BPP16);
  assign direct_word = gfx_big_endian_in ? {gfx_bytes_in[7:0], gfx_bytes_in[15:8]} :
                       gfx_bytes_in;

  // At 1 to 8 bits the pixel value itself is the palette address.
  wire logic [7:0] next_palette_addr;
  assign next_palette_addr = (pix_byte >> pix_shift) & bpp_mask;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      gfx_valid_out <= 1'b0;
      gfx_direct_out <= 1'b0;
      palette_addr_out <= 8'h00;
      direct_color_out <= 16'h0000;
    end else begin
      gfx_valid_out <= gfx_pixel_valid_in;
      if (gfx_pixel_valid_in) begin
        gfx_direct_out <= is_direct;
        palette_addr_out <= is_direct ? 8'h00 : next_palette_addr;
        direct_color_out <= is_direct ? direct_word : 16'h0000;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Register window decode
  // ---------------------------------------------------------------------------

  // Only the top kilobyte of the 8 KB block answers; the rest is ROM or empty.
  // 128 registers fill that kilobyte at eight bytes apart.
  assign mmio_hit_out = (mem_offset_in[12:10] == tad_pkg::MMIO_TOP_KB);
  assign mmio_index_out = mem_offset_in[9:3];
  assign io_index_out = io_offset_in;

endmodule : tad_text_attribute_decoder

/* verification/tad_host_model.sv */
// Purpose: Processor-side model that loads the attribute control settings.
// Assumes: One write strobe, held for one clock; synchronous reset.
// Notes: Bit 7 of a write is the blink enable, bits 6:0 the alternate control.
`timescale 1ns/1ps
module tad_host_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic wr_in,
  input wire logic [7:0] wr_data_in,
  output tad_pkg::tad_alt_ctrl_t alt_ctrl_out,
  output logic blink_en_out
);
  // --------------------------------------------------------------------------
  // Control registers, cleared by reset so decoding starts in the plain format.
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      alt_ctrl_out <= '0;
      blink_en_out <= 1'b0;
    end else if (wr_in) begin
      alt_ctrl_out <= tad_pkg::tad_alt_ctrl_t'(wr_data_in[6:0]);
      blink_en_out <= wr_data_in[7];
    end
  end
endmodule : tad_host_model

/* verification/tad_chk.sv */
// Purpose: Port-level timing and decode checks for the attribute decoder.
// Assumes: One clock domain with a synchronous active-high reset.
// Notes: Attached by a bind in the testbench top file.
`timescale 1ns/1ps
module tad_chk (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic enhanced_variant_in,
  input wire logic legacy_text_mode_in,
  input wire logic wide_text_mode_in,
  input wire logic cell_nine_wide_in,
  input wire tad_pkg::tad_htiming_t htiming_in,
  input wire logic vsync_pulse_in,
  input wire logic text_pixel_valid_in,
  input wire logic gfx_pixel_valid_in,
  input wire logic [12:0] mem_offset_in,
  input wire logic text_color_valid_out,
  input wire logic [3:0] cell_last_col_out,
  input wire logic legacy_cursor_on_out,
  input wire logic [8:0] htotal_chars_out,
  input wire logic [7:0] hsync_end_out,
  input wire logic hsync_end_extended_out,
  input wire logic [15:0] hsync_pos_out,
  input wire logic hsync_pos_extended_out,
  input wire logic hblank_end_b5_out,
  input wire logic gfx_valid_out,
  input wire logic mmio_hit_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // A text pixel counts only while one of the text modes is selected.
  sequence s_text_take;
    text_pixel_valid_in && (legacy_text_mode_in || wide_text_mode_in);
  endsequence
  a_text_answer: assert property (s_text_take |=> text_color_valid_out)
    else $error("text colour not answered");
  a_no_mode_drop: assert property (!(legacy_text_mode_in || wide_text_mode_in)
    |=> !text_color_valid_out) else $error("text colour outside text mode");
  a_cell_width: assert property (cell_last_col_out ==
    ((enhanced_variant_in && cell_nine_wide_in) ? 4'h8 : 4'h7)) else $error("cell width");
  a_htotal_wide: assert property (wide_text_mode_in |->
    htotal_chars_out == {1'b0, htiming_in.htotal} + 9'h001) else $error("wide total");
  a_hsync_end_ext: assert property (wide_text_mode_in |-> hsync_end_extended_out &&
    hsync_end_out == htiming_in.ext_hsync_end) else $error("sync end source");
  a_hsync_pos_ext: assert property (wide_text_mode_in |-> hsync_pos_extended_out &&
    hsync_pos_out == {htiming_in.ext_hsync_pos_hi, htiming_in.ext_hsync_pos_lo})
    else $error("sync position source");
  a_hblank_b5: assert property (hblank_end_b5_out == htiming_in.legacy_hblank_end_b5)
    else $error("blank end bit lost");
  a_mmio_window: assert property (mmio_hit_out ==
    (mem_offset_in[12:10] == tad_pkg::MMIO_TOP_KB)) else $error("window decode");
  a_gfx_answer: assert property (gfx_pixel_valid_in |=> gfx_valid_out)
    else $error("pixel not answered");
  a_blink_hold: assert property (!vsync_pulse_in |=> $stable(legacy_cursor_on_out))
    else $error("blink moved without sync");
endmodule : tad_chk

/* verification/tb.sv */
// Purpose: Self-checking bench comparing the decoder with a behavioural model.
// Assumes: 40 MHz clock, synchronous reset held for five cycles.
// Notes: The cursor is lit only in the closing scenario.
`timescale 1ns/1ps
module tb;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic enhanced_variant_in, legacy_text_mode_in, wide_text_mode_in, opmode_alt_attr_in;
  tad_pkg::tad_alt_ctrl_t alt_ctrl_in;
  tad_pkg::tad_htiming_t htiming_in;
  logic attr_blink_enable_in, cell_nine_wide_in, vsync_pulse_in, text_pixel_valid_in;
  logic font_bit_in, underline_row_in, cursor_cell_in, legacy_cursor_row_in, host_wr;
  logic gfx_pixel_valid_in, gfx_big_endian_in, text_color_valid_out, font_set_sel_out;
  logic alt_attr_active_out, legacy_cursor_on_out, legacy_char_on_out, alt_cursor_on_out;
  logic alt_char_on_out, hsync_end_extended_out, hsync_pos_extended_out, hblank_end_b5_out;
  logic gfx_valid_out, gfx_direct_out, mmio_hit_out;
  logic [3:0] cell_col_in, io_offset_in, text_color_out, cell_last_col_out, io_index_out;
  logic [7:0] attr_byte_in, host_data, hsync_end_out, palette_addr_out;
  logic [15:0] gfx_bytes_in, hsync_pos_out, direct_color_out;
  logic [2:0] gfx_bpp_in, gfx_pixel_num_in;
  logic [12:0] mem_offset_in;
  logic [8:0] htotal_chars_out;
  logic [6:0] mmio_index_out;
  logic [31:0] seed = 32'h9B0D;
  int fails = 0;
  int num_checks = 0;
  int vs_count = 0;
  tad_text_attribute_decoder dut_u (.*);
  tad_host_model host_u (.clk_in(clk_in), .rst_in(rst_in), .wr_in(host_wr),
    .wr_data_in(host_data), .alt_ctrl_out(alt_ctrl_in), .blink_en_out(attr_blink_enable_in));
  always #12.5 clk_in = ~clk_in;
  // --------------------------------------------------------------------------
  // Helpers: random source, comparison, and the closing report.
  // --------------------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run
  // Alternate-format colour of one text pixel, cursor excluded.
  function automatic logic [3:0] exp_color(logic [7:0] a, logic blen, logic f, logic u,
    logic [3:0] c, logic [3:0] last);
    logic [3:0] base, fg, bg;
    base = (!blen && a[7]) ? 4'h8 : 4'h0;
    fg = a[6] ? base : a[3:0];
    bg = a[6] ? a[3:0] : base;
    if (a[4] && u && (c == 4'h0 || c == last))
      return a[5] ? bg : fg;
    if (u && a[5])
      return fg;
    return (f && !(blen && a[7] && vs_count[5] && vs_count[4])) ? fg : bg;
  endfunction : exp_color
  task automatic host_write(input logic [7:0] d);
    @(posedge clk_in);
    host_wr <= 1'b1;
    host_data <= d;
    @(posedge clk_in);
    host_wr <= 1'b0;
  endtask : host_write
  // Text pixels, a new one every two cycles, with random attributes, columns and timing fields.
  task automatic text_run(input int n);
    logic [31:0] r;
    logic [3:0] c, last;
    for (int i = 0; i < n; i++) begin
      @(posedge clk_in);
      r = rnd();
      last = (enhanced_variant_in && cell_nine_wide_in) ? 4'h8 : 4'h7;
      c = (r[13] && last == 4'h8) ? 4'h8 : {1'b0, r[12:10]};
      attr_byte_in <= r[7:0];
      font_bit_in <= r[8];
      underline_row_in <= r[9];
      cell_col_in <= c;
      text_pixel_valid_in <= 1'b1;
      mem_offset_in <= r[28:16];
      io_offset_in <= r[31:28];
      htiming_in <= {r[7:0], rnd()};
      @(posedge clk_in);
      #1;
      chk(16'(text_color_out), 16'(exp_color(r[7:0], attr_blink_enable_in, r[8], r[9], c,
        last)));
      chk(16'({text_color_valid_out, font_set_sel_out}), 16'({1'b1, r[3]}));
      chk(16'(mmio_index_out), 16'(r[25:19]));
      chk(16'(io_index_out), 16'(r[31:28]));
      chk(16'(htotal_chars_out), 16'(htiming_in.htotal) + (wide_text_mode_in ? 1 : 5));
    end
  endtask : text_run
  task automatic pulse_sync(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_in);
      vsync_pulse_in <= 1'b1;
      @(posedge clk_in);
      vsync_pulse_in <= 1'b0;
      vs_count++;
      #1;
      chk(16'({legacy_cursor_on_out, legacy_char_on_out, alt_cursor_on_out, alt_char_on_out}),
        16'({!vs_count[3], !vs_count[4], !vs_count[4], !(vs_count[5] && vs_count[4])}));
    end
  endtask : pulse_sync
  // Every pixel size in turn, random byte pair, pixel number and byte order.
  task automatic gfx_run(input int n);
    logic [31:0] r;
    logic [2:0] codes[5] = '{3'h0, 3'h1, 3'h3, 3'h2, 3'h6};
    int b, k, sh;
    for (int i = 0; i < n; i++) begin
      r = rnd();
      b = 1 << (i % 5);
      k = (b < 16) ? int'(r[2:0]) % (8 / b) : 0;
      sh = r[3] ? 8 - (k + 1) * b : k * b;
      @(posedge clk_in);
      gfx_pixel_valid_in <= 1'b1;
      gfx_bpp_in <= codes[i % 5];
      gfx_pixel_num_in <= 3'(k);
      gfx_big_endian_in <= r[3];
      gfx_bytes_in <= r[31:16];
      @(posedge clk_in);
      #1;
      chk(16'({gfx_valid_out, gfx_direct_out}), (b == 16) ? 16'h0003 : 16'h0002);
      if (b == 16)
        chk(direct_color_out, r[3] ? {r[23:16], r[31:24]} : r[31:16]);
      else
        chk(16'(palette_addr_out), 16'((r[23:16] >> sh) & ((1 << b) - 1)));
    end
  endtask : gfx_run
  // --------------------------------------------------------------------------
  // Main sequence and the hang guard.
  // --------------------------------------------------------------------------
  initial begin
    {enhanced_variant_in, legacy_text_mode_in, wide_text_mode_in, opmode_alt_attr_in} = '0;
    {cell_nine_wide_in, vsync_pulse_in, text_pixel_valid_in, font_bit_in} = '0;
    {underline_row_in, cursor_cell_in, legacy_cursor_row_in, host_wr, host_data} = '0;
    {gfx_pixel_valid_in, gfx_big_endian_in, gfx_bytes_in, gfx_bpp_in} = '0;
    {gfx_pixel_num_in, cell_col_in, io_offset_in, attr_byte_in, mem_offset_in} = '0;
    htiming_in = '0;
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    enhanced_variant_in <= 1'b1;
    wide_text_mode_in <= 1'b1;
    opmode_alt_attr_in <= 1'b1;
    cell_nine_wide_in <= 1'b1;
    host_write(8'h40);
    #1;
    chk(16'(alt_attr_active_out), 16'h0001);
    text_run(40);
    host_write(8'hC0);
    text_run(40);
    pulse_sync(48);
    text_run(40);
    cell_nine_wide_in <= 1'b0;
    text_run(20);
    wide_text_mode_in <= 1'b0;
    legacy_text_mode_in <= 1'b1;
    text_run(10);
    gfx_run(50);
    host_write(8'h5A);
    cursor_cell_in <= 1'b1;
    @(posedge clk_in);
    #1;
    chk(16'(text_color_out), 16'h000A);
    @(posedge clk_in);
    legacy_text_mode_in <= 1'b0;
    @(posedge clk_in);
    #1;
    chk(16'(text_color_valid_out), 16'h0000);
    complete_run();
  end
  initial begin
    repeat (100000) @(posedge clk_in);
    fails++;
    complete_run();
  end
endmodule : tb
bind tad_text_attribute_decoder tad_chk chk_u (.*);
